// file: dac_pacer_pkg.sv
// constants and types shared by the paced output block
package dac_pacer_pkg;
  // counter region byte offsets
  localparam logic [3:0] CTR_IDX_OFS = 4'h8;
  localparam logic [3:0] CTR_LOW_OFS = 4'h9;
  localparam logic [3:0] CTR_HIGH_OFS = 4'hA;
  localparam logic [3:0] CTR_CTRL_OFS = 4'hB;
  // output region offsets
  localparam logic [1:0] OUT_SAMPLE_OFS = 2'h0;
  localparam logic [1:0] OUT_CLEAR_OFS = 2'h2;
  // sample path sizes
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 512;
  localparam int FIFO_CNT_W = 10;
  // oscillator tick derived from the system clock
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int OSC_HZ = 10_000_000;
  localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
  // control word fields
  localparam int CW_SEL_LO = 6;
  localparam int CW_RW_LO = 4;
  localparam int CW_MODE_LO = 1;
  localparam logic [1:0] SEL_NONE = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LOW = 2'h1;
  localparam logic [1:0] RW_HIGH = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [2:0] MODE_TERMINAL = 3'h0;
  localparam logic [2:0] MODE_RATE = 3'h2;
  // counter reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [1:0] RW_RESET = 2'h3;
  localparam logic [2:0] MODE_RESET = 3'h2;
  // target select codes
  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_ZERO = 2'h1;
  localparam logic [1:0] TGT_ONE = 2'h2;
  localparam logic [1:0] TGT_BOTH = 2'h3;
  // zero volt codes per coding
  localparam logic [15:0] ZERO_BIPOLAR = 16'h7FFF;
  localparam logic [15:0] ZERO_UNIPOLAR = 16'h0000;
  typedef enum logic {ST_IDLE, ST_SECOND} route_state_t;
endpackage : dac_pacer_pkg

// file: dac_fifo_pacer_counters.sv
// sample fifo and paced output with its counter bank
// How it works
// - index counter runs from trigger flip-flop set until input fifo half full
// - pacer divider is 32 bits, low counter output clocks high counter
// - low pacer counter counts a fixed 10 MHz oscillator tick
// - high counter output is the internal pacer, selectable as source
// - control port is 8-bit write-only; write mode before count
// - counts are 16 bits loaded as low byte then high byte
// - output data port takes a 16-bit sample word, bit 15 msb
// - bipolar coding is offset binary, 7FFF is zero volts
// - unipolar coding is straight binary, 0000 is zero volts
// - paced output draws only from the fifo filled by word writes
// - target select picks none, channel zero, one, or alternating both
// - fifo location zero is the first sample after a clear
// - any write to the clear port empties the fifo, data ignored
// - the fifo holds 512 samples shared by both channels
// - counter region accesses are single bytes
`timescale 1ns/100ps

module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 512,
  parameter int CNT_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clear,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // flags
  output logic half_q
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(DEPTH / 2);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [CNT_W-1:0] count_q, count_d;
  logic ready_q, valid_q;
  wire push = in_valid && ready_q;
  wire pop = out_ready && valid_q;

  // flags come straight from flops
  assign in_ready = ready_q;
  assign out_valid = valid_q;
  assign out_data = mem[rd_ptr_q];
  assign count_d = clear ? '0 : count_q + CNT_W'(push) - CNT_W'(pop);

  // storage written at the write index
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      wr_ptr_q <= clear ? '0 : wr_ptr_q + PTR_W'(push);
      rd_ptr_q <= clear ? '0 : rd_ptr_q + PTR_W'(pop);
      count_q <= count_d;
      ready_q <= count_d != FULL_CNT;
      valid_q <= count_d != '0;
      half_q <= count_d >= HALF_CNT;
    end
  end
endmodule : sample_fifo

module dac_fifo_pacer_counters
  import dac_pacer_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // counter byte region
  input wire logic [3:0] ctr_addr,
  input wire logic ctr_wr,
  input wire logic ctr_rd,
  input wire logic [7:0] ctr_wdata,
  output logic [7:0] ctr_rdata,
  // output word region
  input wire logic [1:0] out_addr,
  input wire logic out_wr,
  input wire logic [15:0] out_wdata,
  // input side status
  input wire logic pretrig_mode,
  input wire logic adc_trig_ff,
  input wire logic adc_fifo_half_full,
  input wire logic adc_conv_pulse,
  // pacing and routing controls
  input wire logic pacer_sel_internal,
  input wire logic ext_pacer_pulse,
  input wire logic [1:0] output_target_select,
  input wire logic bipolar_mode,
  // channel words and strobes
  output logic [15:0] output_channel_zero,
  output logic [15:0] output_channel_one,
  output logic chan_zero_strobe,
  output logic chan_one_strobe,
  // status
  output logic internal_pacer,
  output logic index_done,
  output logic out_fifo_full_n,
  output logic out_fifo_not_empty,
  output logic out_fifo_half_full
);
  logic [15:0] count_q [3];
  logic [15:0] latch_q [3];
  logic [15:0] reload_q [3];
  logic [7:0] low_q [3];
  logic [1:0] rw_q [3];
  logic [2:0] mode_q [3];
  logic [2:0] wr_hi_q, rd_hi_q, latched_q, armed_q, pulse_q, tc_q, ce;
  logic [$clog2(OSC_DIV)-1:0] div_q;
  logic tick10_q, idx_gate_q, trig_prev_q, phase_q, init_q;
  logic [7:0] rdata_q;
  logic [15:0] ch0_q, ch1_q;
  logic ch0_stb_q, ch1_stb_q;
  route_state_t state_q;

  // next count of one counter on its clock enable
  function automatic logic [15:0] next_count(input logic [2:0] mode, input logic [15:0] cnt,
                                             input logic [15:0] reload);
    if (mode == MODE_TERMINAL) begin
      return (cnt == 16'h0000) ? cnt : cnt - 16'h0001;
    end
    return (cnt == 16'h0001) ? reload : cnt - 16'h0001;
  endfunction : next_count

  // full count assembled from the final byte of a load
  function automatic logic [15:0] load_value(input logic [1:0] rw, input logic [7:0] data,
                                             input logic [7:0] low);
    return (rw == RW_LOW) ? {8'h00, data} : (rw == RW_HIGH) ? {data, 8'h00} : {data, low};
  endfunction : load_value

  // region decode
  wire [1:0] csel = ctr_addr[1:0];
  wire ctr_hit = ctr_addr >= CTR_IDX_OFS && ctr_addr <= CTR_HIGH_OFS;
  wire ctl_wr = ctr_wr && ctr_addr == CTR_CTRL_OFS;
  wire [1:0] cw_sel = ctr_wdata[CW_SEL_LO +: 2];
  wire [1:0] cw_rw = ctr_wdata[CW_RW_LO +: 2];
  wire [2:0] cw_mode = ctr_wdata[CW_MODE_LO +: 3];
  wire sample_wr = out_wr && out_addr == OUT_SAMPLE_OFS;
  wire fifo_clear = out_wr && out_addr == OUT_CLEAR_OFS;
  wire trig_rise = adc_trig_ff && !trig_prev_q;

  // clock enables: oscillator tick, cascade, gated conversions
  assign ce[0] = adc_conv_pulse && idx_gate_q && armed_q[0];
  assign ce[1] = tick10_q && armed_q[1];
  assign ce[2] = pulse_q[1] && armed_q[2];
  wire pacer_tick = pacer_sel_internal ? pulse_q[2] : ext_pacer_pulse;

  // fifo hookup and routing decisions
  wire fifo_valid, fifo_ready, fifo_half;
  wire [15:0] fifo_data;
  wire first_pop = state_q == ST_IDLE && pacer_tick && output_target_select != TGT_NONE;
  wire second_pop = state_q == ST_SECOND;
  wire pop = (first_pop || second_pop) && fifo_valid && !fifo_clear;
  wire to_one = output_target_select == TGT_ONE ||
                (output_target_select == TGT_BOTH && phase_q);

  sample_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH), .CNT_W(FIFO_CNT_W)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clear(fifo_clear),
    .in_valid(sample_wr),
    .in_ready(fifo_ready),
    .in_data(out_wdata),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .half_q(fifo_half)
  );

  // oscillator divider and index gate
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      tick10_q <= 1'b0;
      idx_gate_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      div_q <= (div_q == ($clog2(OSC_DIV))'(OSC_DIV - 1)) ? '0 : div_q + 1'b1;
      tick10_q <= div_q == '0;
      trig_prev_q <= adc_trig_ff;
      if (!pretrig_mode || adc_fifo_half_full) begin
        idx_gate_q <= 1'b0;
      end else if (trig_rise) begin
        idx_gate_q <= 1'b1;
      end
    end
  end

  // counter bank: control word, byte loads, counting
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        count_q[i] <= CNT_RESET;
        latch_q[i] <= CNT_RESET;
        reload_q[i] <= CNT_RESET;
        low_q[i] <= 8'h00;
        rw_q[i] <= RW_RESET;
        mode_q[i] <= MODE_RESET;
      end
      wr_hi_q <= '0;
      rd_hi_q <= '0;
      latched_q <= '0;
      armed_q <= '0;
      pulse_q <= '0;
      tc_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pulse_q[i] <= 1'b0;
        if (ce[i]) begin
          count_q[i] <= next_count(mode_q[i], count_q[i], reload_q[i]);
          pulse_q[i] <= mode_q[i] == MODE_RATE && count_q[i] == 16'h0001;
          if (mode_q[i] == MODE_TERMINAL && count_q[i] == 16'h0001) begin
            tc_q[i] <= 1'b1;
          end
        end
        if (ctl_wr && cw_sel == 2'(i)) begin
          if (cw_rw == RW_LATCH) begin
            latch_q[i] <= count_q[i];
            latched_q[i] <= 1'b1;
          end else begin
            rw_q[i] <= cw_rw;
            mode_q[i] <= cw_mode;
            wr_hi_q[i] <= 1'b0;
            rd_hi_q[i] <= 1'b0;
            armed_q[i] <= 1'b0;
            tc_q[i] <= 1'b0;
          end
        end
        if (ctr_wr && ctr_hit && csel == 2'(i)) begin
          if (rw_q[i] == RW_BOTH && !wr_hi_q[i]) begin
            low_q[i] <= ctr_wdata;
            wr_hi_q[i] <= 1'b1;
            armed_q[i] <= 1'b0;
          end else begin
            count_q[i] <= load_value(rw_q[i], ctr_wdata, low_q[i]);
            reload_q[i] <= load_value(rw_q[i], ctr_wdata, low_q[i]);
            wr_hi_q[i] <= 1'b0;
            armed_q[i] <= 1'b1;
            tc_q[i] <= 1'b0;
          end
        end
        if (ctr_rd && ctr_hit && csel == 2'(i)) begin
          if (rw_q[i] != RW_BOTH || rd_hi_q[i]) begin
            latched_q[i] <= 1'b0;
          end
          if (rw_q[i] == RW_BOTH) begin
            rd_hi_q[i] <= !rd_hi_q[i];
          end
        end
      end
      if (ctr_rd) begin
        rdata_q <= 8'h00; // control and unmapped read zero
        if (ctr_hit) begin
          rdata_q <= (rw_q[csel] == RW_HIGH || (rw_q[csel] == RW_BOTH && rd_hi_q[csel])) ?
                     (latched_q[csel] ? latch_q[csel][15:8] : count_q[csel][15:8]) :
                     (latched_q[csel] ? latch_q[csel][7:0] : count_q[csel][7:0]);
        end
      end
    end
  end

  // routing state and channel latches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      phase_q <= 1'b0;
      init_q <= 1'b1;
      ch0_q <= ZERO_UNIPOLAR;
      ch1_q <= ZERO_UNIPOLAR;
      ch0_stb_q <= 1'b0;
      ch1_stb_q <= 1'b0;
    end else begin
      init_q <= 1'b0;
      ch0_stb_q <= 1'b0;
      ch1_stb_q <= 1'b0;
      if (init_q) begin
        ch0_q <= bipolar_mode ? ZERO_BIPOLAR : ZERO_UNIPOLAR;
        ch1_q <= bipolar_mode ? ZERO_BIPOLAR : ZERO_UNIPOLAR;
      end
      if (pop && to_one) begin
        ch1_q <= fifo_data;
        ch1_stb_q <= 1'b1;
      end else if (pop) begin
        ch0_q <= fifo_data;
        ch0_stb_q <= 1'b1;
      end
      if (fifo_clear) begin
        phase_q <= 1'b0;
        state_q <= ST_IDLE;
      end else begin
        if (pop) begin
          phase_q <= !phase_q;
        end
        state_q <= (first_pop && pop && output_target_select == TGT_BOTH && !phase_q) ?
                   ST_SECOND : ST_IDLE;
      end
    end
  end

  // outputs straight from flops
  assign ctr_rdata = rdata_q;
  assign output_channel_zero = ch0_q;
  assign output_channel_one = ch1_q;
  assign chan_zero_strobe = ch0_stb_q;
  assign chan_one_strobe = ch1_stb_q;
  assign internal_pacer = pulse_q[2];
  assign index_done = tc_q[0];
  assign out_fifo_full_n = fifo_ready;
  assign out_fifo_not_empty = fifo_valid;
  assign out_fifo_half_full = fifo_half;

  // checks
  fifo_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fifo_clear |=> !fifo_valid && !ch0_stb_q && !ch1_stb_q ##1 (!fifo_valid || $past(sample_wr)))
    else $error("fifo not empty after clear");
  gate_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    adc_fifo_half_full |=> !idx_gate_q)
    else $error("index gate open at half full");
  gate_on_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pretrig_mode && trig_rise && !adc_fifo_half_full |=> idx_gate_q)
    else $error("index gate not opened by trigger");
  cascade_clock_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pulse_q[2] |-> $past(pulse_q[1]))
    else $error("upper counter moved without lower output");
  osc_tick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pulse_q[1] |-> $past(tick10_q) && !$past(tick10_q, 2))
    else $error("lower counter not paced by oscillator tick");
  byte_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ctr_wr && ctr_addr == CTR_LOW_OFS && rw_q[1] == RW_BOTH && wr_hi_q[1] && !ctl_wr
    |=> count_q[1] == {$past(ctr_wdata), $past(low_q[1])} && armed_q[1])
    else $error("count not assembled low byte first");
  none_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    output_target_select == TGT_NONE && state_q == ST_IDLE |=> !ch0_stb_q && !ch1_stb_q)
    else $error("sample routed with no target");
  zero_route_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pacer_tick && fifo_valid && output_target_select == TGT_ZERO && state_q == ST_IDLE
    && !fifo_clear |=> ch0_stb_q && ch0_q == $past(fifo_data))
    else $error("tick did not latch channel zero");
  both_pair_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    first_pop && pop && output_target_select == TGT_BOTH && !phase_q
    |=> ch0_stb_q ##1 (ch1_stb_q || !$past(fifo_valid)))
    else $error("pair not routed zero then one");
  location_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fifo_clear |=> !phase_q)
    else $error("location parity not reset by clear");
endmodule : dac_fifo_pacer_counters

// file: host_model.sv
// host software model driving the counter and output regions
`timescale 1ns/100ps
module host_model
  import dac_pacer_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // counter byte region
  output logic [3:0] ctr_addr,
  output logic ctr_wr,
  output logic ctr_rd,
  output logic [7:0] ctr_wdata,
  input wire logic [7:0] ctr_rdata,
  // output word region
  output logic [1:0] out_addr,
  output logic out_wr,
  output logic [15:0] out_wdata
);
  // bus idle at time zero
  initial begin
    ctr_addr = 4'h0;
    ctr_wr = 1'b0;
    ctr_rd = 1'b0;
    ctr_wdata = 8'h00;
    out_addr = 2'h0;
    out_wr = 1'b0;
    out_wdata = 16'h0000;
  end
  // one single-byte write; data inverted once released
  task ctr_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    ctr_addr = a;
    ctr_wdata = d;
    ctr_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    ctr_wr = 1'b0;
    ctr_wdata = ~d;
  endtask : ctr_write
  // one single-byte read, data taken after the taking edge
  task ctr_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    ctr_addr = a;
    ctr_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    ctr_rd = 1'b0;
    d = ctr_rdata;
  endtask : ctr_read
  // mode word first, then count low byte and high byte
  task load_count(input logic [3:0] a, input logic [7:0] cw, input logic [15:0] n);
    ctr_write(CTR_CTRL_OFS, cw);
    ctr_write(a, n[7:0]);
    ctr_write(a, n[15:8]);
  endtask : load_count
  // one word write to the output region
  task out_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    out_addr = a;
    out_wdata = d;
    out_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    out_wr = 1'b0;
    out_wdata = ~d;
  endtask : out_write
endmodule : host_model

// file: tb_top.sv
// self-checking bench for the paced output block
`timescale 1ns/100ps
module tb_top;
  import dac_pacer_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic pretrig_mode;
  logic adc_trig_ff;
  logic adc_fifo_half_full;
  logic adc_conv_pulse;
  logic pacer_sel_internal;
  logic ext_pacer_pulse;
  logic [1:0] output_target_select;
  logic bipolar_mode;
  wire logic [3:0] ctr_addr;
  wire logic ctr_wr;
  wire logic ctr_rd;
  wire logic [7:0] ctr_wdata;
  wire logic [7:0] ctr_rdata;
  wire logic [1:0] out_addr;
  wire logic out_wr;
  wire logic [15:0] out_wdata;
  wire logic [15:0] output_channel_zero;
  wire logic [15:0] output_channel_one;
  wire logic chan_zero_strobe;
  wire logic chan_one_strobe;
  wire logic internal_pacer;
  wire logic index_done;
  wire logic out_fifo_full_n;
  wire logic out_fifo_not_empty;
  wire logic out_fifo_half_full;
  int failures;
  int n_tests;
  int cycles;
  int n;
  logic [15:0] e0;
  logic [15:0] e1;
  logic [15:0] q[$];
  logic [7:0] lo;
  logic [7:0] hi;

  dac_fifo_pacer_counters dac_fifo_pacer_counters_i (.clk_sys, .reset_n, .ctr_addr, .ctr_wr,
    .ctr_rd, .ctr_wdata, .ctr_rdata, .out_addr, .out_wr, .out_wdata, .pretrig_mode,
    .adc_trig_ff, .adc_fifo_half_full, .adc_conv_pulse, .pacer_sel_internal,
    .ext_pacer_pulse, .output_target_select, .bipolar_mode, .output_channel_zero,
    .output_channel_one, .chan_zero_strobe, .chan_one_strobe, .internal_pacer,
    .index_done, .out_fifo_full_n, .out_fifo_not_empty, .out_fifo_half_full);
  host_model host_model_i (.clk_sys, .ctr_addr, .ctr_wr, .ctr_rd, .ctr_wdata, .ctr_rdata,
    .out_addr, .out_wr, .out_wdata);

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      final_report();
    end
  end
  // compare tasks
  task chk_word(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_word
  task chk_flag(input string nm, input logic ex, input logic got);
    n_tests++;
    if (got !== ex) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, ex, got);
    end
  endtask : chk_flag
  task final_report;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // reset and zero-volt codes per coding
  task do_reset(input logic bip);
    reset_n = 1'b0;
    bipolar_mode = bip;
    repeat (6) @(posedge clk_sys);
    #1;
    chk_flag("full_n in reset", 1'b1, out_fifo_full_n);
    reset_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    e0 = bip ? 16'h7FFF : 16'h0000;
    e1 = e0;
    q.delete();
    chk_word("channel zero", e0, output_channel_zero);
    chk_word("channel one", e1, output_channel_one);
  endtask : do_reset
  // fifo access with a reference queue
  task push(input logic [15:0] w);
    host_model_i.out_write(OUT_SAMPLE_OFS, w);
    q.push_back(w);
  endtask : push
  task clr;
    host_model_i.out_write(OUT_CLEAR_OFS, 16'h5A5A);
    q.delete();
  endtask : clr
  // external pacer tick, then both channel words compared
  task tick;
    logic st0;
    logic st1;
    @(posedge clk_sys);
    #1;
    ext_pacer_pulse = 1'b1;
    @(posedge clk_sys);
    #1;
    ext_pacer_pulse = 1'b0;
    st0 = output_target_select[0] && q.size() > 0;
    if (st0) e0 = q.pop_front();
    st1 = output_target_select[1] && q.size() > 0;
    if (st1) e1 = q.pop_front();
    chk_flag("zero strobe", st0, chan_zero_strobe);
    chk_flag("one strobe", st1 && !output_target_select[0], chan_one_strobe);
    @(posedge clk_sys);
    #1;
    chk_flag("one strobe", st1 && output_target_select[0], chan_one_strobe);
    @(posedge clk_sys);
    #1;
    chk_word("channel zero", e0, output_channel_zero);
    chk_word("channel one", e1, output_channel_one);
  endtask : tick
  task conv(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      #1;
      adc_conv_pulse = 1'b1;
      @(posedge clk_sys);
      #1;
      adc_conv_pulse = 1'b0;
    end
  endtask : conv
  // latched read of the index counter
  task read_index(input logic [15:0] ex);
    host_model_i.ctr_write(CTR_CTRL_OFS, 8'h00);
    host_model_i.ctr_read(CTR_IDX_OFS, lo);
    host_model_i.ctr_read(CTR_IDX_OFS, hi);
    chk_word("index count", ex, {hi, lo});
  endtask : read_index

  // main sequence
  initial begin
    {pretrig_mode, adc_trig_ff, adc_fifo_half_full, adc_conv_pulse} = 4'h0;
    {pacer_sel_internal, ext_pacer_pulse} = 2'h0;
    output_target_select = TGT_NONE;
    do_reset(1'b0);
    do_reset(1'b1);
    // location zero after a clear, interleaved routing
    push(16'h1111);
    clr;
    output_target_select = TGT_BOTH;
    push(16'h8001);
    push(16'h0102);
    push(16'hFFFF);
    push(16'h0000);
    chk_flag("not empty", 1'b1, out_fifo_not_empty);
    tick;
    tick;
    chk_flag("not empty", 1'b0, out_fifo_not_empty);
    // none, channel zero only, channel one only
    for (int s = 0; s < 3; s++) begin
      clr;
      output_target_select = s[1:0];
      push(16'hC3A0 | 16'(s));
      push(16'h3C50 | 16'(s));
      tick;
      tick;
      chk_flag("not empty", s == 0, out_fifo_not_empty);
    end
    clr;
    chk_flag("not empty", 1'b0, out_fifo_not_empty);
    // fill to capacity, then one dropped word
    for (int i = 0; i < 512; i++) begin
      if (i == 255 || i == 256) begin
        @(posedge clk_sys);
        #1;
        chk_flag("half full", i == 256, out_fifo_half_full);
      end
      push(16'(i));
    end
    @(posedge clk_sys);
    #1;
    chk_flag("full_n", 1'b0, out_fifo_full_n);
    host_model_i.out_write(OUT_SAMPLE_OFS, 16'hDEAD);
    clr;
    @(posedge clk_sys);
    #1;
    chk_flag("full_n", 1'b1, out_fifo_full_n);
    chk_flag("not empty", 1'b0, out_fifo_not_empty);
    // index counter gated by trigger and half full
    host_model_i.load_count(CTR_IDX_OFS, 8'h30, 16'h0005);
    host_model_i.ctr_read(4'h3, lo);
    chk_word("unmapped read", 16'h0000, {8'h00, lo});
    host_model_i.ctr_read(CTR_CTRL_OFS, lo);
    chk_word("control read", 16'h0000, {8'h00, lo});
    read_index(16'h0005);
    pretrig_mode = 1'b1;
    conv(2);
    adc_trig_ff = 1'b1;
    conv(2);
    adc_fifo_half_full = 1'b1;
    conv(2);
    read_index(16'h0003);
    chk_flag("index done", 1'b0, index_done);
    {adc_trig_ff, adc_fifo_half_full} = 2'h0;
    @(posedge clk_sys);
    #1;
    adc_trig_ff = 1'b1;
    conv(3);
    repeat (2) @(posedge clk_sys);
    #1;
    chk_flag("index done", 1'b1, index_done);
    // internal pacer: 32-bit divider of the oscillator tick
    clr;
    output_target_select = TGT_ZERO;
    push(16'h4321);
    push(16'h8765);
    pacer_sel_internal = 1'b1;
    host_model_i.load_count(CTR_LOW_OFS, 8'h74, 16'h0003);
    host_model_i.load_count(CTR_HIGH_OFS, 8'hB4, 16'h0002);
    n = 0;
    while (internal_pacer !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (internal_pacer !== 1'b1 && n < 200);
    chk_word("pacer period", 16'(OSC_DIV * 6), 16'(n));
    repeat (3) @(posedge clk_sys);
    #1;
    chk_word("channel zero", 16'h8765, output_channel_zero);
    chk_flag("not empty", 1'b0, out_fifo_not_empty);
    final_report();
  end
endmodule : tb_top
